// [rtl/mpc_pkg.sv]
package mpc_pkg;

	// ==========================================================
	// register map
	localparam logic [7:0] ADDR_PIN7_CFG   = 8'h37;
	localparam logic [7:0] ADDR_PIN8_CFG   = 8'h38;
	localparam logic [7:0] ADDR_PIN9_CFG   = 8'h39;
	localparam logic [7:0] ADDR_PIN10_CFG  = 8'h3a;
	localparam logic [7:0] ADDR_ENABLE_CFG = 8'h3c;
	localparam logic [7:0] ADDR_OUT_LOW    = 8'h3d;

	// ==========================================================
	// reset values
	localparam logic [7:0] PIN_CFG_RESET    = 8'h0a;
	localparam logic [7:0] ENABLE_CFG_RESET = 8'h88;
	localparam logic [7:0] OUT_LOW_RESET    = 8'h00;
	localparam logic [7:0] UNMAPPED_READ    = 8'h00;

	// ==========================================================
	// field positions
	localparam int SEL_HI_BIT     = 7;
	localparam int SEL_LO_BIT     = 5;
	localparam int FILTER_BIT     = 4;
	localparam int PULL_EN_BIT    = 3;
	localparam int PULL_DIR_BIT   = 2;
	localparam int DRIVE_OD_BIT   = 1;
	localparam int DIR_BIT        = 0;
	localparam int ENABLE_INPUT_POLARITY_BIT = 5;
	localparam int PIN8_LEVEL_BIT = 7;

	// ==========================================================
	// pins and function codes
	localparam int NUM_PINS = 4;
	localparam int PIN7     = 0;
	localparam int PIN8     = 1;
	localparam int PIN9     = 2;
	localparam int PIN10    = 3;

	localparam logic [2:0] FN_GPIO    = 3'h0;
	localparam logic [2:0] FN_ALT1    = 3'h1;
	localparam logic [2:0] FN_ALT2    = 3'h2;
	localparam logic [2:0] FN_ALT3    = 3'h3;
	localparam logic [2:0] FN_SLEEP_A = 3'h4;
	localparam logic [2:0] FN_SLEEP_B = 3'h5;
	localparam logic [2:0] FN_WAKE_A  = 3'h6;
	localparam logic [2:0] FN_WAKE_B  = 3'h7;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_PS  = 4000;
	localparam int FILTER_TIME_US = 8;
	localparam int FILTER_CYCLES  = (FILTER_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int FILT_CNT_W     = 11;
	localparam logic [FILT_CNT_W-1:0] FILT_CNT_MAX = FILT_CNT_W'(FILTER_CYCLES - 1);

	// ==========================================================
	// carriers
	typedef struct packed {
		logic [2:0] func_sel;
		logic       filter_en;
		logic       pull_en;
		logic       pull_dir;
		logic       drive_od;
		logic       dir;
	} mpc_pin_cfg_s;

	typedef struct packed {
		logic [1:0] rsvd_hi;
		logic       polarity;
		logic [4:0] rsvd_lo;
	} mpc_enable_cfg_s;

	// levels that internal functions want driven onto pins
	typedef struct packed {
		logic reference_output;
		logic pmic_link_clock;
		logic pmic_link_data;
		logic power_good_output;
		logic reset_output;
		logic soc_reset_output;
	} mpc_func_drive_s;

	// levels taken from pins toward internal functions
	typedef struct packed {
		logic mcu_error_input;
		logic voltage_monitor_input_a;
		logic voltage_monitor_input_b;
		logic pmic_link_clock;
		logic pmic_link_data;
		logic sync_clock_input;
		logic sleep_request_a;
		logic sleep_request_b;
		logic wake_input_a;
		logic wake_input_b;
	} mpc_func_in_s;

endpackage : mpc_pkg

// [rtl/mpc_pin_filter.sv]
`timescale 1ns/10ps
module mpc_pin_filter (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic reset_n,
	// pin side
	input  wire logic pad_in,
	input  wire logic filter_en,
	// filtered level
	output logic      level
);

	// ==========================================================
	// two-stage synchroniser
	logic                             sync1_ff;
	logic                             sync2_ff;
	logic                             level_ff;
	logic [mpc_pkg::FILT_CNT_W-1:0]   cnt_ff;

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
		end else begin
			sync1_ff <= pad_in;
			sync2_ff <= sync1_ff;
		end
	end

	// ==========================================================
	// deglitch: a new level must hold for the full window before it passes
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			level_ff <= 1'b0;
			cnt_ff   <= '0;
		end else if (!filter_en) begin
			level_ff <= sync2_ff;
			cnt_ff   <= '0;
		end else if (sync2_ff == level_ff) begin
			cnt_ff <= '0;
		end else if (cnt_ff == mpc_pkg::FILT_CNT_MAX) begin
			level_ff <= sync2_ff;
			cnt_ff   <= '0;
		end else begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	assign level = level_ff;

	AST_FILTER_WINDOW: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$changed(level_ff) && $past(filter_en) |-> $past(cnt_ff) == mpc_pkg::FILT_CNT_MAX)
		else $error("filtered level changed before the deglitch window ran out");

	AST_SYNC_ONLY: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!filter_en |=> level_ff == $past(sync2_ff))
		else $error("unfiltered level does not follow the synchroniser");

endmodule : mpc_pin_filter

// [rtl/mpc_pin_config.sv]
`timescale 1ns/10ps
// Functional notes
// - pin7 codes 0-3 select gpio, mcu error in, reference out, monitor a in.
// - pin8 codes 0-3 select gpio, link clock, then monitor b in twice.
// - pin9 codes 0-3 select gpio, link data, power good out, sync clock in.
// - pin10 codes 0-3 select gpio, reset out, then soc reset out twice.
// - codes 4-7 on any pin select sleep a, sleep b, wake a, wake b.
// - filter bit clear means synchronise only; set adds an 8 us deglitch.
// - pull-enable bit connects the pull resistor; resets to one.
// - pull-direction bit picks down or up, only while pull is enabled.
// - output drive bit picks push-pull or open-drain; resets to one.
// - direction bit picks input or output; resets to input.
// - pin config resets to 0x0a, then takes non-volatile defaults.
// - enable polarity bit makes enable pin active high or active low.
// - enable config resets to 0x88; reserved fields are read-write.
// - general-purpose output on pin 8 follows its output-level register bit; other pins follow ext_output_level.
module mpc_pin_config (
	// clock and reset
	input  wire logic                                       sys_clk,
	input  wire logic                                       reset_n,
	// register port
	input  wire logic [7:0]                                 reg_addr,
	input  wire logic                                       reg_wr_en,
	input  wire logic                                       reg_rd_en,
	input  wire logic [7:0]                                 reg_wdata,
	output logic      [7:0]                                 reg_rdata,
	output logic                                            reg_rvalid,
	// non-volatile defaults
	input  wire logic                                       nvm_load,
	input  wire mpc_pkg::mpc_pin_cfg_s [mpc_pkg::NUM_PINS-1:0] nvm_pin_cfg,
	input  wire logic [7:0]                                 nvm_enable_cfg,
	input  wire logic [7:0]                                 nvm_out_low,
	// pins 7 to 10, index 0 is pin 7
	input  wire logic [mpc_pkg::NUM_PINS-1:0]               pad_in,
	output logic      [mpc_pkg::NUM_PINS-1:0]               pad_out,
	output logic      [mpc_pkg::NUM_PINS-1:0]               pad_oe,
	output logic      [mpc_pkg::NUM_PINS-1:0]               pull_up_en,
	output logic      [mpc_pkg::NUM_PINS-1:0]               pull_down_en,
	// enable pin
	input  wire logic                                       enable_pin,
	output logic                                            enable_active,
	// internal function side
	input  wire mpc_pkg::mpc_func_drive_s                   func_drive,
	input  wire logic [mpc_pkg::NUM_PINS-1:0]               ext_output_level,
	output mpc_pkg::mpc_func_in_s                           func_in
);

	// ==========================================================
	// configuration registers
	mpc_pkg::mpc_pin_cfg_s    pin_cfg_ff [mpc_pkg::NUM_PINS];
	mpc_pkg::mpc_enable_cfg_s enable_cfg_ff;
	logic [7:0]               out_low_ff;
	logic [7:0]               nxt_rdata;
	logic [7:0]               reg_rdata_ff;
	logic                     reg_rvalid_ff;

	// non-volatile load wins over a software write in the same cycle
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			for (int p = 0; p < mpc_pkg::NUM_PINS; p++) begin
				pin_cfg_ff[p] <= mpc_pkg::PIN_CFG_RESET;
			end
		end else if (nvm_load) begin
			for (int p = 0; p < mpc_pkg::NUM_PINS; p++) begin
				pin_cfg_ff[p] <= nvm_pin_cfg[p];
			end
		end else if (reg_wr_en) begin
			for (int p = 0; p < mpc_pkg::NUM_PINS; p++) begin
				if (reg_addr == mpc_pkg::ADDR_PIN7_CFG + 8'(p)) begin
					pin_cfg_ff[p] <= reg_wdata;
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			enable_cfg_ff <= mpc_pkg::ENABLE_CFG_RESET;
		end else if (nvm_load) begin
			enable_cfg_ff <= nvm_enable_cfg;
		end else if (reg_wr_en && reg_addr == mpc_pkg::ADDR_ENABLE_CFG) begin
			enable_cfg_ff <= reg_wdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			out_low_ff <= mpc_pkg::OUT_LOW_RESET;
		end else if (nvm_load) begin
			out_low_ff <= nvm_out_low;
		end else if (reg_wr_en && reg_addr == mpc_pkg::ADDR_OUT_LOW) begin
			out_low_ff <= reg_wdata;
		end
	end

	// ==========================================================
	// read path, answered one cycle after the strobe
	always_comb begin
		nxt_rdata = mpc_pkg::UNMAPPED_READ;
		case (reg_addr)
			mpc_pkg::ADDR_PIN7_CFG:   nxt_rdata = pin_cfg_ff[mpc_pkg::PIN7];
			mpc_pkg::ADDR_PIN8_CFG:   nxt_rdata = pin_cfg_ff[mpc_pkg::PIN8];
			mpc_pkg::ADDR_PIN9_CFG:   nxt_rdata = pin_cfg_ff[mpc_pkg::PIN9];
			mpc_pkg::ADDR_PIN10_CFG:  nxt_rdata = pin_cfg_ff[mpc_pkg::PIN10];
			mpc_pkg::ADDR_ENABLE_CFG: nxt_rdata = enable_cfg_ff;
			mpc_pkg::ADDR_OUT_LOW:    nxt_rdata = out_low_ff;
			default:                  nxt_rdata = mpc_pkg::UNMAPPED_READ;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			reg_rdata_ff  <= 8'h00;
			reg_rvalid_ff <= 1'b0;
		end else begin
			reg_rvalid_ff <= reg_rd_en;
			if (reg_rd_en) begin
				reg_rdata_ff <= nxt_rdata;
			end
		end
	end

	assign reg_rdata  = reg_rdata_ff;
	assign reg_rvalid = reg_rvalid_ff;

	// ==========================================================
	// output level chosen by each pin's function selector
	function automatic logic drive_level(input int pin, input logic [2:0] sel, input logic gpo,
	                                     input mpc_pkg::mpc_func_drive_s drv);
		logic lvl;
		lvl = 1'b0;
		if (sel == mpc_pkg::FN_GPIO) begin
			lvl = gpo;
		end else begin
			case (pin)
				mpc_pkg::PIN7:  lvl = (sel == mpc_pkg::FN_ALT2) ? drv.reference_output : 1'b0;
				mpc_pkg::PIN8:  lvl = (sel == mpc_pkg::FN_ALT1) ? drv.pmic_link_clock : 1'b0;
				mpc_pkg::PIN9: begin
					if (sel == mpc_pkg::FN_ALT1) begin
						lvl = drv.pmic_link_data;
					end else if (sel == mpc_pkg::FN_ALT2) begin
						lvl = drv.power_good_output;
					end
				end
				mpc_pkg::PIN10: begin
					if (sel == mpc_pkg::FN_ALT1) begin
						lvl = drv.reset_output;
					end else if (sel == mpc_pkg::FN_ALT2 || sel == mpc_pkg::FN_ALT3) begin
						lvl = drv.soc_reset_output;
					end
				end
				default: lvl = 1'b0;
			endcase
		end
		return lvl;
	endfunction : drive_level

	// ==========================================================
	// per-pin drivers and input filters
	logic [mpc_pkg::NUM_PINS-1:0] gpo_level;
	logic [mpc_pkg::NUM_PINS-1:0] filtered;
	logic [mpc_pkg::NUM_PINS-1:0] pad_out_ff;
	logic [mpc_pkg::NUM_PINS-1:0] pad_oe_ff;
	logic [mpc_pkg::NUM_PINS-1:0] pull_up_ff;
	logic [mpc_pkg::NUM_PINS-1:0] pull_down_ff;

	// only pin 8's level lives here; the others come from output registers outside
	always_comb begin
		gpo_level                = ext_output_level;
		gpo_level[mpc_pkg::PIN8] = out_low_ff[mpc_pkg::PIN8_LEVEL_BIT];
	end

	for (genvar p = 0; p < mpc_pkg::NUM_PINS; p++) begin : g_pin
		logic lvl;
		assign lvl = drive_level(p, pin_cfg_ff[p].func_sel, gpo_level[p], func_drive);

		// open-drain only ever pulls low, so a high level releases the pin
		always_ff @(posedge sys_clk) begin
			if (!reset_n) begin
				pad_out_ff[p] <= 1'b0;
				pad_oe_ff[p]  <= 1'b0;
			end else if (!pin_cfg_ff[p].dir) begin
				pad_out_ff[p] <= 1'b0;
				pad_oe_ff[p]  <= 1'b0;
			end else if (pin_cfg_ff[p].drive_od) begin
				pad_out_ff[p] <= 1'b0;
				pad_oe_ff[p]  <= ~lvl;
			end else begin
				pad_out_ff[p] <= lvl;
				pad_oe_ff[p]  <= 1'b1;
			end
		end

		always_ff @(posedge sys_clk) begin
			if (!reset_n) begin
				pull_up_ff[p]   <= 1'b0;
				pull_down_ff[p] <= 1'b0;
			end else begin
				pull_up_ff[p]   <= pin_cfg_ff[p].pull_en & pin_cfg_ff[p].pull_dir;
				pull_down_ff[p] <= pin_cfg_ff[p].pull_en & ~pin_cfg_ff[p].pull_dir;
			end
		end

		mpc_pin_filter u_filter (
			.sys_clk   (sys_clk),
			.reset_n   (reset_n),
			.pad_in    (pad_in[p]),
			.filter_en (pin_cfg_ff[p].filter_en),
			.level     (filtered[p])
		);

		AST_INPUT_RELEASED: assert property (@(posedge sys_clk) disable iff (!reset_n)
			!pin_cfg_ff[p].dir |=> !pad_oe_ff[p])
			else $error("input pin is being driven");

		AST_OD_NO_HIGH: assert property (@(posedge sys_clk) disable iff (!reset_n)
			pad_oe_ff[p] && pad_out_ff[p] |-> !$past(pin_cfg_ff[p].drive_od))
			else $error("open-drain pin driven high");

		AST_PULL_GATED: assert property (@(posedge sys_clk) disable iff (!reset_n)
			!pin_cfg_ff[p].pull_en |=> !pull_up_ff[p] && !pull_down_ff[p])
			else $error("pull resistor active while disabled");

		AST_PIN_RESET: assert property (@(posedge sys_clk)
			!reset_n |=> pin_cfg_ff[p] == mpc_pkg::PIN_CFG_RESET)
			else $error("pin config reset value wrong");

		AST_NVM_LOAD: assert property (@(posedge sys_clk) disable iff (!reset_n)
			nvm_load |=> pin_cfg_ff[p] == $past(nvm_pin_cfg[p]))
			else $error("non-volatile default not taken");
	end

	assign pad_out      = pad_out_ff;
	assign pad_oe       = pad_oe_ff;
	assign pull_up_en   = pull_up_ff;
	assign pull_down_en = pull_down_ff;

	// ==========================================================
	// route input pins to internal functions; several pins on one function are ORed
	mpc_pkg::mpc_func_in_s nxt_func_in;
	mpc_pkg::mpc_func_in_s func_in_ff;

	always_comb begin
		nxt_func_in = '0;
		for (int p = 0; p < mpc_pkg::NUM_PINS; p++) begin
			if (!pin_cfg_ff[p].dir) begin
				case (pin_cfg_ff[p].func_sel)
					mpc_pkg::FN_SLEEP_A: nxt_func_in.sleep_request_a |= filtered[p];
					mpc_pkg::FN_SLEEP_B: nxt_func_in.sleep_request_b |= filtered[p];
					mpc_pkg::FN_WAKE_A:  nxt_func_in.wake_input_a    |= filtered[p];
					mpc_pkg::FN_WAKE_B:  nxt_func_in.wake_input_b    |= filtered[p];
					default: begin
					end
				endcase
			end
		end
		if (!pin_cfg_ff[mpc_pkg::PIN7].dir) begin
			if (pin_cfg_ff[mpc_pkg::PIN7].func_sel == mpc_pkg::FN_ALT1) begin
				nxt_func_in.mcu_error_input = filtered[mpc_pkg::PIN7];
			end
			if (pin_cfg_ff[mpc_pkg::PIN7].func_sel == mpc_pkg::FN_ALT3) begin
				nxt_func_in.voltage_monitor_input_a = filtered[mpc_pkg::PIN7];
			end
		end
		if (!pin_cfg_ff[mpc_pkg::PIN8].dir) begin
			if (pin_cfg_ff[mpc_pkg::PIN8].func_sel == mpc_pkg::FN_ALT1) begin
				nxt_func_in.pmic_link_clock = filtered[mpc_pkg::PIN8];
			end
			if (pin_cfg_ff[mpc_pkg::PIN8].func_sel == mpc_pkg::FN_ALT2 ||
			    pin_cfg_ff[mpc_pkg::PIN8].func_sel == mpc_pkg::FN_ALT3) begin
				nxt_func_in.voltage_monitor_input_b = filtered[mpc_pkg::PIN8];
			end
		end
		if (!pin_cfg_ff[mpc_pkg::PIN9].dir) begin
			if (pin_cfg_ff[mpc_pkg::PIN9].func_sel == mpc_pkg::FN_ALT1) begin
				nxt_func_in.pmic_link_data = filtered[mpc_pkg::PIN9];
			end
			if (pin_cfg_ff[mpc_pkg::PIN9].func_sel == mpc_pkg::FN_ALT3) begin
				nxt_func_in.sync_clock_input = filtered[mpc_pkg::PIN9];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			func_in_ff <= '0;
		end else begin
			func_in_ff <= nxt_func_in;
		end
	end

	assign func_in = func_in_ff;

	// ==========================================================
	// enable pin: synchronise only, then apply polarity
	logic enable_sync1_ff;
	logic enable_sync2_ff;
	logic enable_active_ff;

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			enable_sync1_ff  <= 1'b0;
			enable_sync2_ff  <= 1'b0;
			enable_active_ff <= 1'b0;
		end else begin
			enable_sync1_ff  <= enable_pin;
			enable_sync2_ff  <= enable_sync1_ff;
			enable_active_ff <= enable_sync2_ff ^ enable_cfg_ff.polarity;
		end
	end

	assign enable_active = enable_active_ff;

	// ==========================================================
	// checks across the block
	sequence seq_enable_high_pol_high;
		(enable_pin && !enable_cfg_ff.polarity)[*4];
	endsequence

	sequence seq_enable_low_pol_low;
		(!enable_pin && enable_cfg_ff.polarity)[*4];
	endsequence

	AST_ENABLE_ACTIVE_HIGH: assert property (@(posedge sys_clk) disable iff (!reset_n)
		seq_enable_high_pol_high |=> enable_active_ff)
		else $error("active-high enable not seen");

	AST_ENABLE_ACTIVE_LOW: assert property (@(posedge sys_clk) disable iff (!reset_n)
		seq_enable_low_pol_low |=> enable_active_ff)
		else $error("active-low enable not seen");

	AST_ENABLE_RESET: assert property (@(posedge sys_clk)
		!reset_n |=> enable_cfg_ff == mpc_pkg::ENABLE_CFG_RESET)
		else $error("enable config reset value wrong");

	AST_PIN8_GPO: assert property (@(posedge sys_clk) disable iff (!reset_n)
		pin_cfg_ff[mpc_pkg::PIN8].func_sel == mpc_pkg::FN_GPIO && pin_cfg_ff[mpc_pkg::PIN8].dir &&
		!pin_cfg_ff[mpc_pkg::PIN8].drive_od |=> pad_out_ff[mpc_pkg::PIN8] == $past(out_low_ff[mpc_pkg::PIN8_LEVEL_BIT]))
		else $error("pin 8 output does not follow its level bit");

	AST_SLEEP_ROUTE: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!pin_cfg_ff[mpc_pkg::PIN9].dir && pin_cfg_ff[mpc_pkg::PIN9].func_sel == mpc_pkg::FN_SLEEP_A &&
		filtered[mpc_pkg::PIN9] |=> func_in_ff.sleep_request_a)
		else $error("sleep request not routed from pin 9");

	AST_PIN10_SOC_RESET: assert property (@(posedge sys_clk) disable iff (!reset_n)
		pin_cfg_ff[mpc_pkg::PIN10].func_sel == mpc_pkg::FN_ALT3 && pin_cfg_ff[mpc_pkg::PIN10].dir &&
		!pin_cfg_ff[mpc_pkg::PIN10].drive_od |=> pad_out_ff[mpc_pkg::PIN10] == $past(func_drive.soc_reset_output))
		else $error("pin 10 code 3 does not carry soc reset");

endmodule : mpc_pin_config

// [testbench/mpc_host_model.sv]
`timescale 1ns/10ps
module mpc_host_model (
	// clock
	input  wire logic       sys_clk,
	// device pin drive and pulls
	input  wire logic [3:0] pad_out,
	input  wire logic [3:0] pad_oe,
	input  wire logic [3:0] pull_up_en,
	input  wire logic [3:0] pull_down_en,
	// host drive
	input  wire logic [3:0] host_oe,
	input  wire logic [3:0] host_drv,
	// resolved wire levels
	output logic      [3:0] pad_level
);
	logic [3:0] last_ff = 4'h0;

	// ==========================================================
	// wire resolution
	// a pin nobody drives or pulls toggles each cycle, so stale values never look valid
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (pad_oe[i])
				pad_level[i] = pad_out[i];
			else if (host_oe[i])
				pad_level[i] = host_drv[i];
			else if (pull_up_en[i])
				pad_level[i] = 1'b1;
			else if (pull_down_en[i])
				pad_level[i] = 1'b0;
			else
				pad_level[i] = ~last_ff[i];
		end
	end

	always_ff @(posedge sys_clk) begin
		last_ff <= pad_level;
	end
endmodule : mpc_host_model

// [testbench/test_mpc_pin_config.sv]
`timescale 1ns/10ps
module test_mpc_pin_config;
	logic                                          sys_clk = 1'b0;
	logic                                          reset_n = 1'b0;
	logic [7:0]                                    reg_addr = 8'h00;
	logic                                          reg_wr_en = 1'b0;
	logic                                          reg_rd_en = 1'b0;
	logic [7:0]                                    reg_wdata = 8'h00;
	logic [7:0]                                    reg_rdata;
	logic                                          reg_rvalid;
	logic                                          nvm_load = 1'b0;
	mpc_pkg::mpc_pin_cfg_s [mpc_pkg::NUM_PINS-1:0] nvm_pin_cfg = '0;
	logic [7:0]                                    nvm_enable_cfg = 8'h00;
	logic [7:0]                                    nvm_out_low = 8'h00;
	logic [3:0]                                    pad_in, pad_out, pad_oe, pull_up_en, pull_down_en;
	logic [3:0]                                    host_oe = 4'h0;
	logic [3:0]                                    host_drv = 4'h0;
	logic                                          enable_pin = 1'b0;
	logic                                          enable_active;
	mpc_pkg::mpc_func_drive_s                      func_drive = '0;
	logic [3:0]                                    ext_output_level = 4'h0;
	mpc_pkg::mpc_func_in_s                         func_in;
	int                                            miscompares = 0;
	int                                            n_compared = 0;
	int                                            k, idx;
	// func_in bit per pin and code, -1 where nothing is fed
	int in_map [4][8] = '{'{-1, 9, -1, 8, 3, 2, 1, 0}, '{-1, 6, 7, 7, 3, 2, 1, 0},
		'{-1, 5, -1, 4, 3, 2, 1, 0}, '{-1, -1, -1, -1, 3, 2, 1, 0}};
	// func_drive bit per pin and code, -2 general purpose, -1 no source
	int out_map [4][8] = '{'{-2, -1, 5, -1, -1, -1, -1, -1}, '{-2, 4, -1, -1, -1, -1, -1, -1},
		'{-2, 3, 2, -1, -1, -1, -1, -1}, '{-2, 1, 0, 0, -1, -1, -1, -1}};
	logic [7:0] addrs [6] = '{8'h37, 8'h38, 8'h39, 8'h3a, 8'h3c, 8'h3d};

	always #2 sys_clk = ~sys_clk;

	mpc_pin_config uut (
		.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.nvm_load(nvm_load), .nvm_pin_cfg(nvm_pin_cfg), .nvm_enable_cfg(nvm_enable_cfg),
		.nvm_out_low(nvm_out_low), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .enable_pin(enable_pin),
		.enable_active(enable_active), .func_drive(func_drive), .ext_output_level(ext_output_level),
		.func_in(func_in));

	mpc_host_model u_host (
		.sys_clk(sys_clk), .pad_out(pad_out), .pad_oe(pad_oe), .pull_up_en(pull_up_en),
		.pull_down_en(pull_down_en), .host_oe(host_oe), .host_drv(host_drv), .pad_level(pad_in));

	// ==========================================================
	// helpers
	task automatic end_of_test();
		if (miscompares == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		#1 reg_wr_en = 1'b1;
		reg_addr = a;
		reg_wdata = v;
		@(posedge sys_clk);
		#1 reg_wr_en = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		int n;
		@(posedge sys_clk);
		#1 reg_rd_en = 1'b1;
		reg_addr = a;
		@(posedge sys_clk);
		#1 reg_rd_en = 1'b0;
		n = 0;
		while (reg_rvalid !== 1'b1 && n < 4) begin
			cyc(1);
			n++;
		end
		if (reg_rvalid !== 1'b1) begin
			miscompares++;
			end_of_test();
		end
		v = reg_rdata;
	endtask : rd

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd(a, v);
		chk("register", {a, v}, {a, exp});
	endtask : rchk

	task automatic do_reset();
		reset_n = 1'b0;
		cyc(5);
		reset_n = 1'b1;
	endtask : do_reset

	task automatic reset_values();
		for (int i = 0; i < 4; i++)
			rchk(addrs[i], mpc_pkg::PIN_CFG_RESET);
		rchk(8'h3c, 8'h88);
		rchk(8'h3d, 8'h00);
	endtask : reset_values

	// ==========================================================
	// main sequence
	initial begin
		do_reset();
		reset_values();
		rchk(8'h3b, 8'h00);
		for (int i = 0; i < 6; i++)
			wr(addrs[i], 8'ha5 ^ 8'(i));
		wr(8'h3b, 8'hff);
		for (int i = 0; i < 6; i++)
			rchk(addrs[i], 8'ha5 ^ 8'(i));
		rchk(8'h3b, 8'h00);
		nvm_pin_cfg = 32'h91642fe3;
		nvm_enable_cfg = 8'h5a;
		nvm_out_low = 8'hc3;
		nvm_load = 1'b1;
		cyc(1);
		nvm_load = 1'b0;
		for (int i = 0; i < 4; i++)
			rchk(addrs[i], nvm_pin_cfg[i]);
		rchk(8'h3c, 8'h5a);
		rchk(8'h3d, 8'hc3);
		do_reset();
		reset_values();
		// output functions, each source checked at both levels
		for (int p = 0; p < 4; p++) begin
			for (int c = 0; c < 8; c++) begin
				wr(addrs[p], {3'(c), 5'b00001});
				idx = out_map[p][c];
				for (int lv = 1; lv >= 0; lv--) begin
					if (idx == -2) begin
						ext_output_level = lv ? 4'hf : 4'h0;
						wr(8'h3d, lv ? 8'h80 : 8'h00);
					end
					else if (idx >= 0)
						func_drive = lv ? 6'(1 << idx) : ~6'(1 << idx);
					else
						func_drive = lv ? 6'h3f : 6'h00;
					cyc(3);
					chk("pad_out", {pad_oe[p], pad_out[p]}, {1'b1, 1'(lv && idx != -1)});
				end
			end
			wr(addrs[p], 8'h00);
		end
		// open drain on pin 8
		wr(8'h38, 8'h03);
		wr(8'h3d, 8'h80);
		cyc(3);
		chk("open_drain_high", {pad_oe[1], pad_out[1]}, 2'b00);
		wr(8'h3d, 8'h00);
		cyc(3);
		chk("open_drain_low", {pad_oe[1], pad_out[1]}, 2'b10);
		// pull controls on pin 9
		wr(8'h39, 8'h0c);
		cyc(3);
		chk("pull_up", {pull_up_en[2], pull_down_en[2]}, 2'b10);
		wr(8'h39, 8'h08);
		cyc(3);
		chk("pull_down", {pull_up_en[2], pull_down_en[2]}, 2'b01);
		wr(8'h39, 8'h04);
		cyc(3);
		chk("pull_off", {pull_up_en[2], pull_down_en[2]}, 2'b00);
		// input functions
		wr(8'h38, 8'h00);
		host_oe = 4'hf;
		for (int p = 0; p < 4; p++) begin
			for (int c = 0; c < 8; c++) begin
				wr(addrs[p], {3'(c), 5'b00000});
				host_drv = 4'h0;
				host_drv[p] = 1'b1;
				cyc(6);
				idx = in_map[p][c];
				chk("func_in_high", {6'h00, func_in}, idx >= 0 ? 16'(1 << idx) : 16'h0000);
				chk("pad_oe_input", {12'h000, pad_oe}, 16'h0000);
				host_drv = 4'h0;
				cyc(6);
				chk("func_in_low", {6'h00, func_in}, 16'h0000);
			end
			wr(addrs[p], 8'h00);
		end
		// deglitch on pin 7 as sleep request a
		wr(8'h37, 8'h90);
		cyc(10);
		host_drv[0] = 1'b1;
		cyc(100);
		host_drv[0] = 1'b0;
		cyc(10);
		chk("glitch_blocked", {15'h0000, func_in[3]}, 16'h0000);
		host_drv[0] = 1'b1;
		k = 0;
		while (func_in[3] !== 1'b1 && k < 2100) begin
			cyc(1);
			k++;
		end
		chk("filter_delay", {15'h0000, 1'(k >= mpc_pkg::FILTER_CYCLES && k <= mpc_pkg::FILTER_CYCLES + 8)}, 16'h0001);
		// a filter that never lets the level through ends the run here
		if (func_in[3] !== 1'b1)
			end_of_test();
		// enable polarity
		enable_pin = 1'b1;
		cyc(5);
		chk("enable_high", {15'h0000, enable_active}, 16'h0001);
		wr(8'h3c, 8'ha8);
		cyc(5);
		chk("enable_low_pol", {15'h0000, enable_active}, 16'h0000);
		enable_pin = 1'b0;
		cyc(5);
		chk("enable_low_pin", {15'h0000, enable_active}, 16'h0001);
		end_of_test();
	end
endmodule : test_mpc_pin_config
